// ### hdl/tsc_regs.vh
`ifndef TSC_REGS_VH
`define TSC_REGS_VH
// =========================================================
// target addresses and general call
`define TSC_ADDR_A 7'h44
`define TSC_ADDR_B 7'h45
`define TSC_ADDR_C 7'h46
`define TSC_GCALL_ADDR 7'h00
`define TSC_GCALL_RESET 8'h06
// =========================================================
// command bytes
`define TSC_CMD_MEAS_HI 8'hFD
`define TSC_CMD_MEAS_MED 8'hF6
`define TSC_CMD_MEAS_LO 8'hF0
`define TSC_CMD_SERIAL 8'h89
`define TSC_CMD_SOFT_RESET 8'h94
// =========================================================
// checksum
`define TSC_CRC_POLY 8'h31
`define TSC_CRC_SEED 8'hFF
`define TSC_CRC_XOROUT 8'h00
// =========================================================
// timing, in microseconds, and clock rate in kHz
`define TSC_CLK_KHZ 20000
`define TSC_MEAS_LO_US 1600
`define TSC_MEAS_MED_US 4500
`define TSC_MEAS_HI_US 8300
`define TSC_SOFT_RESET_RECOVERY_US 1000
// longest times round down
`define TSC_MEAS_LO_CYC ((`TSC_MEAS_LO_US * `TSC_CLK_KHZ) / 1000)
`define TSC_MEAS_MED_CYC ((`TSC_MEAS_MED_US * `TSC_CLK_KHZ) / 1000)
`define TSC_MEAS_HI_CYC ((`TSC_MEAS_HI_US * `TSC_CLK_KHZ) / 1000)
`define TSC_RST_CYC ((`TSC_SOFT_RESET_RECOVERY_US * `TSC_CLK_KHZ) / 1000)
`endif

// ### hdl/tsc_crc8.v
`default_nettype none
`include "tsc_regs.vh"
// =========================================================
// combinational crc-8 over one 16-bit word, msb first
module tsc_crc8 (
    // data in
    input wire [15:0] word_i,
    // checksum out
    output reg [7:0] crc_o
);
    integer i;
    reg [7:0] c;
    always @* begin
        c = `TSC_CRC_SEED;
        for (i = 15; i >= 0; i = i - 1) begin
            if (c[7] ^ word_i[i]) begin
                c = {c[6:0], 1'b0} ^ `TSC_CRC_POLY;
            end else begin
                c = {c[6:0], 1'b0};
            end
        end
        crc_o = c ^ `TSC_CRC_XOROUT;
    end
endmodule
`default_nettype wire

// ### hdl/tsc_otp.v
`default_nettype none
`include "tsc_regs.vh"
// =========================================================
// one-time-programmable serial store: read port only
module tsc_otp #(
    // arbitrary neutral value
    parameter [31:0] SERIAL = 32'h1234_5678
) (
    // clock
    input wire core_clk_i,
    // read port
    input wire [1:0] idx_i,
    output reg [7:0] rdata_o
);
    // no write path exists, so no command can alter it
    always @(posedge core_clk_i) begin
        case (idx_i)
            2'h0: rdata_o <= SERIAL[31:24];
            2'h1: rdata_o <= SERIAL[23:16];
            2'h2: rdata_o <= SERIAL[15:8];
            default: rdata_o <= SERIAL[7:0];
        endcase
    end
endmodule
`default_nettype wire

// ### hdl/tsc_i2c_target.v
`default_nettype none
`include "tsc_regs.vh"
module tsc_i2c_target #(
    parameter [6:0] DEV_ADDR = `TSC_ADDR_A,
    parameter [31:0] MEAS_LO_CYC = `TSC_MEAS_LO_CYC,
    parameter [31:0] MEAS_MED_CYC = `TSC_MEAS_MED_CYC,
    parameter [31:0] MEAS_HI_CYC = `TSC_MEAS_HI_CYC,
    parameter [31:0] RST_CYC = `TSC_RST_CYC
) (
    // clock and reset
    input wire core_clk_i,
    input wire srst_i,
    // i2c pins (open drain)
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // sensing core
    input wire [15:0] temp_code_i,
    output reg [1:0] meas_mode_o,
    output reg meas_busy_o
);
    // =========================================================
    // pin synchronisers: three flops, change when 2nd and 3rd agree
    reg [2:0] scl_sync_ff;
    reg [2:0] sda_sync_ff;
    reg scl_ff;
    reg sda_ff;
    // filtered levels track the agreed value; edges from them
    wire scl_now = (scl_sync_ff[1] == scl_sync_ff[2]) ?
        scl_sync_ff[2] : scl_ff;
    wire sda_now = (sda_sync_ff[1] == sda_sync_ff[2]) ?
        sda_sync_ff[2] : sda_ff;
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
            scl_ff <= scl_now;
            sda_ff <= sda_now;
        end
    end
    wire scl_rise = scl_now & ~scl_ff;
    wire scl_fall = ~scl_now & scl_ff;
    // start/stop framing is the controller's, we only detect it
    wire start_det = scl_ff & scl_now & sda_ff & ~sda_now;
    wire stop_det = scl_ff & scl_now & ~sda_ff & sda_now;
    // =========================================================
    // byte engine states
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_AACK = 3'h2;
    localparam [2:0] S_WR = 3'h3;
    localparam [2:0] S_WACK = 3'h4;
    localparam [2:0] S_RD = 3'h5;
    localparam [2:0] S_RACK = 3'h6;
    // command tracker states
    localparam [1:0] C_IDLE = 2'h0;
    localparam [1:0] C_MEAS = 2'h1;
    localparam [1:0] C_RESET = 2'h2;
    localparam [1:0] C_READY = 2'h3;
    // kind of reply held after a command
    localparam [1:0] R_NONE = 2'h0;
    localparam [1:0] R_TEMP = 2'h1;
    localparam [1:0] R_SER = 2'h2;
    reg [2:0] st_ff;
    reg [2:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg is_read_ff;
    reg is_gcall_ff;
    reg [2:0] byte_idx_ff;
    reg [1:0] cst_ff;
    reg [1:0] reply_ff;
    reg [31:0] timer_ff;
    reg [15:0] result_ff;
    reg [1:0] otp_idx_ff;
    wire [7:0] otp_byte;
    wire [7:0] crc_temp;
    wire [7:0] crc_ser0;
    wire [7:0] crc_ser1;
    reg [15:0] ser_w0_ff;
    reg [15:0] ser_w1_ff;
    reg [2:0] ser_load_ff;
    // =========================================================
    // serial store and checksums
    tsc_otp u_otp (
        .core_clk_i(core_clk_i),
        .idx_i(otp_idx_ff),
        .rdata_o(otp_byte)
    );
    tsc_crc8 u_crc_t (
        .word_i(result_ff),
        .crc_o(crc_temp)
    );
    tsc_crc8 u_crc_s0 (
        .word_i(ser_w0_ff),
        .crc_o(crc_ser0)
    );
    tsc_crc8 u_crc_s1 (
        .word_i(ser_w1_ff),
        .crc_o(crc_ser1)
    );
    // =========================================================
    // next byte to send: msb first, crc after each pair
    reg [7:0] tx_byte;
    always @* begin
        tx_byte = 8'hFF;
        if (reply_ff == R_TEMP) begin
            case (byte_idx_ff)
                3'h0: tx_byte = result_ff[15:8];
                3'h1: tx_byte = result_ff[7:0];
                3'h2: tx_byte = crc_temp;
                default: tx_byte = 8'hFF;
            endcase
        end else if (reply_ff == R_SER) begin
            case (byte_idx_ff)
                3'h0: tx_byte = ser_w0_ff[15:8];
                3'h1: tx_byte = ser_w0_ff[7:0];
                3'h2: tx_byte = crc_ser0;
                3'h3: tx_byte = ser_w1_ff[15:8];
                3'h4: tx_byte = ser_w1_ff[7:0];
                3'h5: tx_byte = crc_ser1;
                default: tx_byte = 8'hFF;
            endcase
        end
    end
    wire [7:0] rx_byte = {shift_ff[6:0], sda_now};
    wire addr_me = (shift_ff[7:1] == DEV_ADDR);
    wire addr_gc = (rx_byte[7:1] == `TSC_GCALL_ADDR) & ~rx_byte[0];
    // read header only acked when a reply is ready
    wire rd_ok = (cst_ff == C_READY);
    wire wr_done = (st_ff == S_WR) & scl_rise & (bit_cnt_ff == 3'h7);
    wire do_reset = wr_done & (is_gcall_ff ? (rx_byte == `TSC_GCALL_RESET) :
        (rx_byte == `TSC_CMD_SOFT_RESET));
    // =========================================================
    // bit level engine; timing follows scl so all speed modes work
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            st_ff <= S_IDLE;
            bit_cnt_ff <= 3'h0;
            shift_ff <= 8'h00;
            is_read_ff <= 1'b0;
            is_gcall_ff <= 1'b0;
            byte_idx_ff <= 3'h0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (start_det) begin
            st_ff <= S_ADDR;
            bit_cnt_ff <= 3'h0;
            byte_idx_ff <= 3'h0;
            sda_oe_o <= 1'b0;
        end else if (stop_det) begin
            st_ff <= S_IDLE;
            sda_oe_o <= 1'b0;
        end else begin
            case (st_ff)
                S_ADDR: begin
                    if (scl_rise) begin
                        shift_ff <= rx_byte;
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == 3'h7) begin
                            st_ff <= S_AACK;
                            is_read_ff <= rx_byte[0];
                            is_gcall_ff <= addr_gc;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        if (sda_oe_o) begin
                            sda_oe_o <= 1'b0;
                            if (is_read_ff) begin
                                st_ff <= S_RD;
                                sda_oe_o <= ~tx_byte[7];
                                shift_ff <= {tx_byte[6:0], 1'b1};
                            end else begin
                                st_ff <= S_WR;
                            end
                        end else if ((addr_me & ~is_read_ff) | is_gcall_ff
                                | (addr_me & is_read_ff & rd_ok)) begin
                            sda_oe_o <= 1'b1;
                        end else begin
                            st_ff <= S_IDLE;
                        end
                    end
                end
                S_WR: begin
                    if (scl_rise) begin
                        shift_ff <= rx_byte;
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == 3'h7) begin
                            st_ff <= S_WACK;
                        end
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        if (sda_oe_o) begin
                            sda_oe_o <= 1'b0;
                            st_ff <= S_WR;
                        end else begin
                            sda_oe_o <= 1'b1;
                        end
                    end
                end
                S_RD: begin
                    if (scl_fall) begin
                        bit_cnt_ff <= bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == 3'h7) begin
                            sda_oe_o <= 1'b0;
                            st_ff <= S_RACK;
                            byte_idx_ff <= byte_idx_ff + 3'h1;
                        end else begin
                            sda_oe_o <= ~shift_ff[7];
                            shift_ff <= {shift_ff[6:0], 1'b1};
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        // nack ends the read, at any byte
                        if (sda_now) begin
                            st_ff <= S_IDLE;
                        end
                    end else if (scl_fall) begin
                        st_ff <= S_RD;
                        sda_oe_o <= ~tx_byte[7];
                        shift_ff <= {tx_byte[6:0], 1'b1};
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end
    // =========================================================
    // command tracker: measurement timers and reset recovery
    wire cmd_meas = wr_done & ~is_gcall_ff & (cst_ff != C_RESET) &
        ((rx_byte == `TSC_CMD_MEAS_HI) | (rx_byte == `TSC_CMD_MEAS_MED) |
        (rx_byte == `TSC_CMD_MEAS_LO));
    wire cmd_ser = wr_done & ~is_gcall_ff & (cst_ff != C_RESET) &
        (rx_byte == `TSC_CMD_SERIAL);
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            cst_ff <= C_IDLE;
            reply_ff <= R_NONE;
            meas_mode_o <= 2'h0;
            meas_busy_o <= 1'b0;
            ser_load_ff <= 3'h0;
        end else if (do_reset) begin
            // abandon whatever runs; recovery lasts the full 1 ms
            cst_ff <= C_RESET;
            reply_ff <= R_NONE;
            meas_busy_o <= 1'b0;
            timer_ff <= RST_CYC;
            ser_load_ff <= 3'h0;
        end else if (cmd_meas) begin
            cst_ff <= C_MEAS;
            reply_ff <= R_TEMP;
            meas_busy_o <= 1'b1;
            if (rx_byte == `TSC_CMD_MEAS_HI) begin
                timer_ff <= MEAS_HI_CYC;
                meas_mode_o <= 2'h2;
            end else if (rx_byte == `TSC_CMD_MEAS_MED) begin
                timer_ff <= MEAS_MED_CYC;
                meas_mode_o <= 2'h1;
            end else begin
                timer_ff <= MEAS_LO_CYC;
                meas_mode_o <= 2'h0;
            end
        end else if (cmd_ser) begin
            // serial bytes fetched one per cycle from the store
            cst_ff <= C_MEAS;
            reply_ff <= R_SER;
            timer_ff <= 32'h0000_0006;
            otp_idx_ff <= 2'h0;
            ser_load_ff <= 3'h1;
        end else begin
            if (ser_load_ff != 3'h0) begin
                ser_load_ff <= ser_load_ff + 3'h1;
                otp_idx_ff <= otp_idx_ff + 2'h1;
                case (ser_load_ff)
                    3'h2: ser_w0_ff[15:8] <= otp_byte;
                    3'h3: ser_w0_ff[7:0] <= otp_byte;
                    3'h4: ser_w1_ff[15:8] <= otp_byte;
                    3'h5: ser_w1_ff[7:0] <= otp_byte;
                    3'h1: ser_load_ff <= 3'h2; // store read in flight
                    default: ser_load_ff <= 3'h0;
                endcase
            end
            case (cst_ff)
                C_MEAS: begin
                    if (timer_ff <= 32'h0000_0001) begin
                        cst_ff <= C_READY;
                        meas_busy_o <= 1'b0;
                        if (reply_ff == R_TEMP) begin
                            result_ff <= temp_code_i;
                        end
                    end else begin
                        timer_ff <= timer_ff - 32'h0000_0001;
                    end
                end
                C_RESET: begin
                    if (timer_ff <= 32'h0000_0001) begin
                        cst_ff <= C_IDLE;
                    end else begin
                        timer_ff <= timer_ff - 32'h0000_0001;
                    end
                end
                default: cst_ff <= cst_ff;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### bench/tsc_checker.sv
`default_nettype none
module tsc_checker #(
    parameter [31:0] MEAS_LO_CYC = 32'h0000_012C,
    parameter [31:0] MEAS_MED_CYC = 32'h0000_01F4,
    parameter [31:0] MEAS_HI_CYC = 32'h0000_02BC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    // sensing core
    input wire logic [15:0] temp_code_i,
    input wire logic [1:0] meas_mode_o,
    input wire logic meas_busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);
    // =========================================================
    // busy length counter
    logic [31:0] lim;
    logic [31:0] nxt_busy_cnt;
    logic [31:0] busy_cnt_ff;
    always_comb begin
        lim = MEAS_HI_CYC;
        if (meas_mode_o == 2'h0) lim = MEAS_LO_CYC;
        if (meas_mode_o == 2'h1) lim = MEAS_MED_CYC;
        nxt_busy_cnt = meas_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    always_ff @(posedge core_clk_i) begin
        if (srst_i) busy_cnt_ff <= 32'h0;
        else busy_cnt_ff <= nxt_busy_cnt;
    end
    // =========================================================
    // properties
    sequence s_busy_start;
        $rose(meas_busy_o);
    endsequence
    sequence s_busy_end;
        ##[1:1000] $fell(meas_busy_o);
    endsequence
    property p_od_low;
        sda_o == 1'b0;
    endproperty
    // a change while scl is high would read as a start or stop
    property p_sda_scl_low;
        $changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2);
    endproperty
    property p_oe_hold;
        $rose(sda_oe_o) |-> sda_oe_o [*6];
    endproperty
    property p_mode_legal;
        meas_busy_o |-> meas_mode_o != 2'h3;
    endproperty
    property p_mode_stable;
        meas_busy_o && $past(meas_busy_o) |-> $stable(meas_mode_o);
    endproperty
    property p_busy_cap;
        meas_busy_o |-> busy_cnt_ff <= lim + 32'h2;
    endproperty
    property p_busy_ends;
        s_busy_start |-> s_busy_end;
    endproperty
    property p_reset_idle;
        $fell(srst_i) |-> !sda_oe_o && !meas_busy_o ##1 !sda_oe_o;
    endproperty
    a_od_low: assert property (p_od_low)
        else $error("sda data value not low");
    a_sda_scl_low: assert property (p_sda_scl_low)
        else $error("sda moved while scl high");
    a_oe_hold: assert property (p_oe_hold)
        else $error("driven bit too short");
    a_mode_legal: assert property (p_mode_legal)
        else $error("illegal measure mode");
    a_mode_stable: assert property (p_mode_stable)
        else $error("mode moved during measurement");
    a_busy_cap: assert property (p_busy_cap)
        else $error("measurement too long");
    a_busy_ends: assert property (p_busy_ends)
        else $error("measurement never ended");
    a_reset_idle: assert property (p_reset_idle)
        else $error("not idle after reset");
endmodule
`default_nettype wire

// ### bench/tsc_ctrl_model.sv
`default_nettype none
module tsc_ctrl_model #(
    parameter int GAP_CYC = 40
) (
    // clock
    input wire logic clk_i,
    // bus
    input wire logic sda_i,
    output var logic scl_o,
    output var logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx [0:5];
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // =========================================================
    // bit level: eight core cycles per scl period
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // data moves one cycle after scl falls, never while scl is high
    // low phase of five: the target answers four cycles after a fall
    task automatic bit_io(input logic b, output logic r);
        tick(1);
        sda_oe_o <= ~b;
        tick(4);
        scl_o <= 1'b1;
        tick(3);
        r = sda_i;
        scl_o <= 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(last, r);
    endtask
    // controller view of a result, in hundredths of a degree
    function automatic int centi_c(input logic [7:0] hi,
                                   input logic [7:0] lo);
        return -4500 + (17500 * int'({hi, lo})) / 65535;
    endfunction
    // =========================================================
    // framing
    task automatic start_cond();
        tick(GAP_CYC);
        sda_oe_o <= 1'b1;
        tick(4);
        scl_o <= 1'b0;
    endtask
    task automatic stop_cond();
        tick(1);
        sda_oe_o <= 1'b1;
        tick(4);
        scl_o <= 1'b1;
        tick(4);
        sda_oe_o <= 1'b0;
    endtask
    task automatic write_cmd(input logic [6:0] a, input logic [7:0] c,
                             output logic ack);
        logic a2;
        start_cond();
        put_byte({a, 1'b0}, ack);
        a2 = 1'b0;
        if (ack) put_byte(c, a2);
        ack = ack & a2;
        stop_cond();
    endtask
    task automatic read_data(input logic [6:0] a, input int n,
                             output logic ack);
        start_cond();
        put_byte({a, 1'b1}, ack);
        for (int i = 0; i < n; i++) begin
            if (ack) get_byte(i == n - 1, rx[i]);
        end
        stop_cond();
    endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    // shortened times keep the run small
    localparam logic [31:0] LO_CYC = 32'h0000_012C;
    localparam logic [31:0] MED_CYC = 32'h0000_01F4;
    localparam logic [31:0] HI_CYC = 32'h0000_02BC;
    localparam logic [31:0] RST_CYC = 32'h0000_012C;
    localparam logic [6:0] ADDR = 7'h44;
    // arbitrary serial value, the store's default
    localparam logic [31:0] SERIAL = 32'h1234_5678;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [15:0] temp_code_i = 16'h0000;
    wire logic scl_w;
    wire logic sda_w;
    wire logic sda_d;
    wire logic sda_oe_d;
    wire logic sda_oe_c;
    wire logic busy;
    wire logic [1:0] mode;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    always #25 core_clk_i = ~core_clk_i;
    // pull-up on the data wire
    assign sda_w = ~(sda_oe_d | sda_oe_c);
    tsc_i2c_target #(.DEV_ADDR(ADDR), .MEAS_LO_CYC(LO_CYC),
        .MEAS_MED_CYC(MED_CYC), .MEAS_HI_CYC(HI_CYC), .RST_CYC(RST_CYC)
    ) dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_w),
        .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe_d),
        .temp_code_i(temp_code_i), .meas_mode_o(mode), .meas_busy_o(busy));
    tsc_ctrl_model #(.GAP_CYC(40)) ctrl (.clk_i(core_clk_i), .sda_i(sda_w),
        .scl_o(scl_w), .sda_oe_o(sda_oe_c));
    // =========================================================
    // helpers
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (!ok) begin
            err_total++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    function automatic logic [7:0] crc_of(input logic [15:0] w);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
        end
        return c;
    endfunction
    task automatic chk_word(input int k, input logic [15:0] w, input int n);
        chk(ctrl.rx[k] === w[15:8], "msb byte wrong");
        chk(ctrl.rx[k + 1] === w[7:0], "lsb byte wrong");
        if (n > 2) chk(ctrl.rx[k + 2] === crc_of(w), "crc wrong");
    endtask
    task automatic wait_idle(input int lim);
        int i;
        i = 0;
        while (busy !== 1'b0 && i < lim) begin
            @(posedge core_clk_i);
            i++;
        end
        chk(i < lim, "busy did not drop in time");
    endtask
    // =========================================================
    // scenarios
    task automatic t_meas(input logic [7:0] c, input logic [1:0] m,
                          input logic [15:0] code, input int n);
        logic ack;
        int cc;
        cc = -4500 + (17500 * int'(code)) / 65535;
        temp_code_i <= code;
        ctrl.write_cmd(ADDR, c, ack);
        chk(ack === 1'b1, "command refused");
        ctrl.read_data(ADDR, 3, ack);
        chk(ack === 1'b0, "read acked while busy");
        chk(busy === 1'b1 && mode === m, "wrong measure mode");
        wait_idle(1000);
        ctrl.read_data(ADDR, n, ack);
        chk(ack === 1'b1, "result read refused");
        chk_word(0, code, n);
        chk(ctrl.centi_c(ctrl.rx[0], ctrl.rx[1]) == cc, "bad deg");
    endtask
    task automatic t_serial();
        logic ack;
        ctrl.write_cmd(ADDR, 8'h89, ack);
        chk(ack === 1'b1, "serial command refused");
        ctrl.read_data(ADDR, 6, ack);
        chk(ack === 1'b1, "serial read refused");
        chk_word(0, SERIAL[31:16], 3);
        chk_word(3, SERIAL[15:0], 3);
    endtask
    task automatic t_addr();
        logic ack;
        ctrl.write_cmd(7'h45, 8'hFD, ack);
        chk(ack === 1'b0 && busy === 1'b0, "foreign address taken");
    endtask
    task automatic t_reset(input logic gc);
        logic ack;
        ctrl.write_cmd(ADDR, 8'hFD, ack);
        if (gc) ctrl.write_cmd(7'h00, 8'h06, ack);
        else ctrl.write_cmd(ADDR, 8'h94, ack);
        chk(ack === 1'b1, "reset not acked");
        wait_idle(50);
        ctrl.read_data(ADDR, 3, ack);
        chk(ack === 1'b0, "stale data after reset");
        repeat (RST_CYC) @(posedge core_clk_i);
        t_meas(8'hF0, 2'h0, 16'h0001, 3);
    endtask
    // =========================================================
    // run and verdict
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        t_addr();
        t_meas(8'hFD, 2'h2, 16'hBEEF, 3);
        t_meas(8'hF6, 2'h1, 16'h8000, 3);
        t_meas(8'hF0, 2'h0, 16'h7FFF, 3);
        t_meas(8'hFD, 2'h2, 16'h00FF, 2);
        t_serial();
        t_reset(1'b0);
        t_reset(1'b1);
        stop_test();
    end
endmodule
bind tsc_i2c_target tsc_checker #(.MEAS_LO_CYC(MEAS_LO_CYC),
    .MEAS_MED_CYC(MEAS_MED_CYC), .MEAS_HI_CYC(MEAS_HI_CYC)
) u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i), .scl_i(scl_i),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .temp_code_i(temp_code_i), .meas_mode_o(meas_mode_o),
    .meas_busy_o(meas_busy_o));
`default_nettype wire
